//--- mcrc_cfg.svh
// Constants for the multichannel reset controller.
// Assumes a 10 MHz master clock; included by the package and the design.
`ifndef MCRC_CFG_SVH
`define MCRC_CFG_SVH
`define MCRC_NCH            4
`define MCRC_CLK_NS         100
`define MCRC_POR_NS         1000000
`define MCRC_POR_CYC        ((`MCRC_POR_NS) / (`MCRC_CLK_NS))
`define MCRC_SW_NS          1000
`define MCRC_SW_CYC         ((`MCRC_SW_NS) / (`MCRC_CLK_NS))
`define MCRC_LOSS_NS        10000
`define MCRC_LOSS_CYC       ((`MCRC_LOSS_NS) / (`MCRC_CLK_NS))
`define MCRC_CNT_W          14
`define MCRC_ADDR_W         11
`define MCRC_ADDR_GRST      11'h040
`define MCRC_ADDR_CHANNEL_CONFIG_REG      11'h001
`define MCRC_CH_STRIDE      11'h010
`define MCRC_ADDR_STAT      11'h7F0
`define MCRC_BIT_CHANNEL_SOFT_RESET_BIT      1
`define MCRC_BIT_STD        0
`define MCRC_CHANNEL_CONFIG_REG_RST       8'h00
`define MCRC_CHANNEL_CONFIG_REG_WMASK     8'h01
`endif

//--- mcrc_host_model.sv
// Partner model: the board reset circuitry and the host processor.
// Assumes the register port of mcrc_top and a clock from the testbench.
`timescale 1ns/1ps
module mcrc_host_model (
   input  wire logic                clk,
   input  wire logic [7:0]          rdata,
   output logic                     rst_n_pin,
   output logic                     clk_alive,
   output mcrc_pkg::mcrc_req_t      req
);
   import mcrc_pkg::*;
   // ----------------------------------------
   // Idle levels and host bus cycles
   // ----------------------------------------
   // Bus idles quiet; the board holds the pin high and the clock present
   initial begin
      rst_n_pin = 1'b1;
      clk_alive = 1'b1;
      req       = '0;
   end
   // One-cycle write strobe beside address and data
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [10:0] a, output logic [7:0] d);
      @(posedge clk);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req <= '0;
      #1;
      d = rdata;
   endtask
   // Callers keep the pin low well beyond 10 cycles
   task automatic set_pin(input logic v);
      @(posedge clk);
      rst_n_pin <= v;
   endtask
   // Clock presence as seen by the board
   task automatic set_alive(input logic v);
      @(posedge clk);
      clk_alive <= v;
   endtask
endmodule

//--- mcrc_pkg.sv
// Types shared by the multichannel reset controller.
// Assumes mcrc_cfg.svh is on the include path.
`include "mcrc_cfg.svh"
package mcrc_pkg;
   // Register port request
   typedef struct packed {
      logic [10:0] addr;
      logic [7:0]  wdata;
      logic        wr;
      logic        rd;
   } mcrc_req_t;
   // Sequencer states for the global reset
   typedef enum logic [1:0] {
      MCRC_POR  = 2'b00,
      MCRC_HOLD = 2'b01,
      MCRC_SW   = 2'b10,
      MCRC_RUN  = 2'b11
   } mcrc_state_t;
endpackage

//--- mcrc_top.sv
// Reset controller: merges power-on, pin, global and per-channel soft resets.
// Assumes clk is the master clock; rst_n_pin and clk_alive come from outside.
`timescale 1ns/1ps
`include "mcrc_cfg.svh"

// Functional notes
// (R1) Four sources; channel reset only own channel
// (R2) Global resets reset common blocks and channels
// (R3) Line pins high impedance during reset
// (R4) Line pins tristated per affected scope
// (R5) System interface returns to dual-rail NRZ
// (R6) Global reset makes data and GPIO inputs
// (R7) State machines reset per scope
// (R8) Interrupt sources masked per scope
// (R9) Global reset restores all register defaults
// (R10) Channel reset keeps line-standard bit
// (R11) Power-on completes within 1 ms
// (R12) Low reset pin holds device reset
// (R13) Board holds pin low over 1 us
// (R14) Global soft reset completes within 1 us
// (R15) Channel reset bit self-clears within 1 us
// (R16) Channel reset spares common logic
// (R17) Channel reset spares other channels
// (R18) Clock lost after 10 us low duty
// (R19) Clock return triggers automatic reset
// (R20) Channel reset is global or own request
module mcrc_top (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               rst_n_pin,
   input  wire logic               clk_alive,
   input  wire mcrc_pkg::mcrc_req_t req,
   output logic [7:0]              rdata,
   output logic                    common_rst,
   output logic [3:0]              chan_rst,
   output logic [3:0]              line_oe,
   output logic [3:0]              sys_nrz,
   output logic [3:0]              int_mask,
   output logic                    host_pins_in,
   output logic                    power_down
);
   import mcrc_pkg::*;

   // -------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------
   logic [1:0] pin_sync_q, alive_sync_q;
   logic       pin_n, alive;
   // Pins cross from the board; reset to idle level so no false low follows reset
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin_sync_q   <= 2'b11;
         alive_sync_q <= 2'b11;
      end else begin
         pin_sync_q   <= {pin_sync_q[0], rst_n_pin};
         alive_sync_q <= {alive_sync_q[0], clk_alive};
      end
   end
   assign pin_n = pin_sync_q[1];
   assign alive = alive_sync_q[1];

   // Address decode shared by reads and writes
   function automatic logic is_channel_config_reg(input logic [10:0] a, input int ch);
      is_channel_config_reg = (a == 11'(`MCRC_ADDR_CHANNEL_CONFIG_REG + ch * `MCRC_CH_STRIDE));
   endfunction

   // -------------------------------------------------
   // Global sequencer
   // -------------------------------------------------
   mcrc_state_t st_q, st_d;
   logic [`MCRC_CNT_W-1:0] cnt_q, cnt_d;
   logic [`MCRC_CNT_W-1:0] loss_q, loss_d;
   logic lost_q, lost_d;
   logic grst_wr;
   assign grst_wr = req.wr && (req.addr == `MCRC_ADDR_GRST);

   // Loss timer counts cycles without alive indication
   always_comb begin
      loss_d = loss_q;
      lost_d = lost_q;
      if (alive) begin
         loss_d = '0;
         lost_d = 1'b0;
      end else if (loss_q >= `MCRC_CNT_W'(`MCRC_LOSS_CYC - 1)) begin
         lost_d = 1'b1; // R18
      end else begin
         loss_d = loss_q + 1'b1;
      end
   end

   // Pin and lost clock hold reset; sources reload the counter
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      case (st_q)
         MCRC_POR: begin
            if (!pin_n || lost_q) begin
               st_d = MCRC_HOLD; // R12
            end else if (cnt_q >= `MCRC_CNT_W'(`MCRC_POR_CYC - 1)) begin
               st_d = MCRC_RUN; // R11
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         MCRC_HOLD: begin
            cnt_d = '0;
            if (pin_n && !lost_q) begin
               st_d = MCRC_SW; // R19
            end
         end
         MCRC_SW: begin
            if (!pin_n || lost_q) begin
               st_d = MCRC_HOLD;
            end else if (cnt_q >= `MCRC_CNT_W'(`MCRC_SW_CYC - 2)) begin
               st_d  = MCRC_RUN; // R14
               cnt_d = '0;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         default: begin
            cnt_d = '0;
            if (!pin_n || lost_q) begin
               st_d = MCRC_HOLD; // R12
            end else if (grst_wr) begin
               st_d = MCRC_SW; // R14
            end
         end
      endcase
   end

   // Power-on reset starts the sequencer; pin reads high until sampled
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q   <= MCRC_POR;
         cnt_q  <= '0;
         loss_q <= '0;
         lost_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         loss_q <= loss_d;
         lost_q <= lost_d;
      end
   end

   logic glob;
   assign glob = (st_q != MCRC_RUN);

   // -------------------------------------------------
   // Per-channel registers and resets
   // -------------------------------------------------
   logic [3:0] std_q, std_d, crst_q, crst_d;
   logic [`MCRC_NCH-1:0][3:0] ccnt_q, ccnt_d;

   genvar g;
   generate
      for (g = 0; g < `MCRC_NCH; g++) begin : gch
         // Channel bit self-clears after a fixed count; global wipes all
         always_comb begin
            std_d[g]  = std_q[g];
            crst_d[g] = crst_q[g];
            ccnt_d[g] = ccnt_q[g];
            if (glob) begin
               std_d[g]  = 1'b0; // R9
               crst_d[g] = 1'b0;
               ccnt_d[g] = '0;
            end else if (crst_q[g]) begin
               if (ccnt_q[g] >= 4'(`MCRC_SW_CYC - 2)) begin
                  crst_d[g] = 1'b0; // R15
                  ccnt_d[g] = '0;
               end else begin
                  ccnt_d[g] = ccnt_q[g] + 1'b1;
               end
            end else if (req.wr && is_channel_config_reg(req.addr, g)) begin
               // Line-standard bit survives the channel reset
               std_d[g]  = req.wdata[`MCRC_BIT_STD]; // R10
               crst_d[g] = req.wdata[`MCRC_BIT_CHANNEL_SOFT_RESET_BIT]; // R15
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         std_q  <= '0;
         crst_q <= '0;
         ccnt_q <= '0;
      end else begin
         std_q  <= std_d;
         crst_q <= crst_d;
         ccnt_q <= ccnt_d;
      end
   end

   // -------------------------------------------------
   // Outputs and read data
   // -------------------------------------------------
   logic [3:0] ch_any;
   logic [7:0] rdata_d;
   assign ch_any = {4{glob}} | crst_q; // R20 R17

   // Reads: channel config or status word
   always_comb begin
      rdata_d = 8'h00;
      if (req.rd && req.addr == `MCRC_ADDR_STAT) begin
         rdata_d = {2'b00, lost_q, glob, crst_q};
      end else if (req.rd) begin
         for (int c = 0; c < `MCRC_NCH; c++) begin
            if (is_channel_config_reg(req.addr, c)) begin
               rdata_d = {6'h00, crst_q[c], std_q[c]};
            end
         end
      end
   end

   // Every output is a flop; reset state is the safe state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata        <= 8'h00;
         common_rst   <= 1'b1;
         chan_rst     <= 4'hF;
         line_oe      <= 4'h0;
         sys_nrz      <= 4'hF;
         int_mask     <= 4'hF;
         host_pins_in <= 1'b1;
         power_down   <= 1'b0;
      end else begin
         rdata        <= rdata_d;
         common_rst   <= glob; // R2 R16
         chan_rst     <= ch_any; // R1 R7
         line_oe      <= ~ch_any; // R3 R4
         // Default-forcing levels stand while a reset covers that scope
         sys_nrz      <= ch_any; // R5
         int_mask     <= ch_any; // R8
         host_pins_in <= glob; // R6
         power_down   <= lost_q; // R18
      end
   end

   // -------------------------------------------------
   // Checks
   // -------------------------------------------------
   // Length of the current global reset window, for the timing checks
   logic [`MCRC_CNT_W-1:0] glen_q, glen_d;
   always_comb begin
      glen_d = '0;
      if (glob) begin
         // Saturate so a long pin hold cannot wrap the count
         glen_d = (glen_q == '1) ? glen_q : glen_q + 1'b1;
      end
   end

   // Helper register only; kept apart from the design state
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         glen_q <= '0;
      end else begin
         glen_q <= glen_d;
      end
   end

   chan_scope_a: assert property (@(posedge clk) disable iff (rst) // R17
      (!glob && crst_q[0] && !crst_q[1]) |=> !chan_rst[1])
      else $error("channel reset leaked to another channel");
   line_hiz_a: assert property (@(posedge clk) disable iff (rst) // R3
      glob |=> (line_oe == 4'h0))
      else $error("line pins driven during reset");
   sw_done_a: assert property (@(posedge clk) disable iff (rst) // R14
      (st_q == MCRC_RUN && grst_wr && pin_n && !lost_q) |=> ##9
         (!glob && glen_q == `MCRC_CNT_W'(`MCRC_SW_CYC - 1)))
      else $error("global soft reset length wrong");
   por_len_a: assert property (@(posedge clk) disable iff (rst) // R11
      ($fell(glob) && $past(st_q) == MCRC_POR) |-> glen_q == `MCRC_CNT_W'(`MCRC_POR_CYC))
      else $error("power-on reset length wrong");
   host_keep_a: assert property (@(posedge clk) disable iff (rst) // R6
      (!glob && |crst_q) |=> !host_pins_in)
      else $error("channel reset forced host pins to input");
   host_in_a: assert property (@(posedge clk) disable iff (rst) // R6
      glob |=> host_pins_in)
      else $error("host pins not input during global reset");
   nrz_all_a: assert property (@(posedge clk) disable iff (rst) // R5
      glob |=> (sys_nrz == 4'hF))
      else $error("system interface not forced during global reset");
   mask_scope_a: assert property (@(posedge clk) disable iff (rst) // R8
      (!glob && crst_q[1] && !crst_q[2]) |=> (int_mask[1] && !int_mask[2]))
      else $error("interrupt mask scope wrong");
   std_clr_a: assert property (@(posedge clk) disable iff (rst) // R9
      glob |=> (std_q == 4'h0))
      else $error("global reset left a register set");
   chbit_clr_a: assert property (@(posedge clk) disable iff (rst) // R15
      $rose(crst_q[0]) && !glob |-> ##[1:10] !crst_q[0])
      else $error("channel bit did not self clear");
   pin_hold_a: assert property (@(posedge clk) disable iff (rst) // R12
      !pin_n |=> glob)
      else $error("reset pin low but not in reset");
   loss_pd_a: assert property (@(posedge clk) disable iff (rst) // R18
      lost_q |=> power_down)
      else $error("power down missing on clock loss");
   std_keep_a: assert property (@(posedge clk) disable iff (rst) // R10
      (!glob && crst_q[0]) |=> std_q[0] == $past(std_q[0]))
      else $error("line standard bit disturbed");
   common_a: assert property (@(posedge clk) disable iff (rst) // R16
      (!glob && |crst_q) |=> !common_rst)
      else $error("channel reset hit common logic");
endmodule

//--- tb_multichannel_reset_controller.sv
// Testbench for the reset controller, driving it through the host model.
// Assumes mcrc_cfg.svh on the include path and a 100 ns clock.
`timescale 1ns/1ps
`include "mcrc_cfg.svh"
module tb_multichannel_reset_controller;
   import mcrc_pkg::*;
   logic                clk = 1'b0;
   logic                rst = 1'b1;
   logic                rst_n_pin;
   logic                clk_alive;
   mcrc_req_t           req;
   logic [7:0]          rdata;
   logic                common_rst;
   logic [3:0]          chan_rst;
   logic [3:0]          line_oe;
   logic [3:0]          sys_nrz;
   logic [3:0]          int_mask;
   logic                host_pins_in;
   logic                power_down;
   int                  miscompares = 0;
   int                  compares = 0;
   int                  cycles = 0;
   logic [7:0]          d;
   int                  n;
   // ----------------------------------------
   // Clock, instances and checking helpers
   // ----------------------------------------
   always #50 clk = ~clk;
   mcrc_top uut (.clk(clk), .rst(rst), .rst_n_pin(rst_n_pin), .clk_alive(clk_alive), .req(req),
      .rdata(rdata), .common_rst(common_rst), .chan_rst(chan_rst), .line_oe(line_oe),
      .sys_nrz(sys_nrz), .int_mask(int_mask), .host_pins_in(host_pins_in), .power_down(power_down));
   mcrc_host_model u_host (.clk(clk), .rdata(rdata), .rst_n_pin(rst_n_pin), .clk_alive(clk_alive),
      .req(req));
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bounded wait until every reset output has dropped
   task automatic settle(input int lim, output int k);
      k = 0;
      while ((common_rst !== 1'b0 || chan_rst !== 4'h0) && k < lim) begin
         @(posedge clk);
         #1;
         k++;
      end
   endtask
   task automatic wrap_up;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Hang guard: the full run needs about 10300 cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         wrap_up();
      end
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_por;
      repeat (3) @(posedge clk);
      #1;
      chk(8'({common_rst, chan_rst}), 8'h1F);
      chk(8'(line_oe), 8'h00);
      chk(8'({host_pins_in, int_mask}), 8'h1F);
      chk(8'({power_down, sys_nrz}), 8'h0F);
      @(posedge clk);
      rst <= 1'b0;
      repeat (5000) @(posedge clk);
      #1;
      chk(8'(common_rst), 8'h01);
      settle(6000, n);
      chk(8'(n < 6000), 8'h01);
   endtask
   task automatic t_glob;
      u_host.wr(`MCRC_ADDR_GRST, 8'hA5);
      repeat (3) @(posedge clk);
      #1;
      chk(8'({common_rst, chan_rst}), 8'h1F);
      chk(8'(line_oe), 8'h00);
      chk(8'({sys_nrz, int_mask}), 8'hFF);
      chk(8'(host_pins_in), 8'h01);
      settle(20, n);
      chk(8'(n <= 10), 8'h01);
   endtask
   // Each channel reset with the line-standard bit set alongside
   task automatic t_chan;
      for (int c = 0; c < 4; c++) begin
         u_host.wr(11'(`MCRC_ADDR_CHANNEL_CONFIG_REG + `MCRC_CH_STRIDE * c), 8'h03);
         repeat (3) @(posedge clk);
         #1;
         chk(8'({common_rst, chan_rst}), 8'(4'h1 << c));
         chk(8'(line_oe[c]), 8'h00);
         chk(8'({sys_nrz, int_mask}), 8'({4'h1 << c, 4'h1 << c}));
         chk(8'(host_pins_in), 8'h00);
         settle(20, n);
         chk(8'(n <= 10), 8'h01);
         u_host.rd(11'(`MCRC_ADDR_CHANNEL_CONFIG_REG + `MCRC_CH_STRIDE * c), d);
         chk(d, 8'h01);
      end
      u_host.rd(11'h7FF, d);
      chk(d, 8'h00);
      u_host.rd(`MCRC_ADDR_STAT, d);
      chk(d, 8'h00);
   endtask
   // Pin held low twice the minimum, then released
   task automatic t_pin;
      u_host.set_pin(1'b0);
      repeat (20) @(posedge clk);
      #1;
      chk(8'({common_rst, chan_rst}), 8'h1F);
      chk(8'(line_oe), 8'h00);
      u_host.set_pin(1'b1);
      settle(10100, n);
      chk(8'(n < 10100), 8'h01);
      u_host.rd(`MCRC_ADDR_CHANNEL_CONFIG_REG, d);
      chk(d, 8'h00);
   endtask
   task automatic t_loss;
      u_host.set_alive(1'b0);
      repeat (90) @(posedge clk);
      #1;
      chk(8'(power_down), 8'h00);
      repeat (20) @(posedge clk);
      #1;
      chk(8'(power_down), 8'h01);
      u_host.rd(`MCRC_ADDR_STAT, d);
      chk(d, 8'h30);
      u_host.set_alive(1'b1);
      repeat (6) @(posedge clk);
      #1;
      chk(8'(common_rst), 8'h01);
      settle(100, n);
      chk(8'({n < 100, n >= 5, power_down}), 8'h06);
   endtask
   initial begin
      t_por();
      t_glob();
      t_chan();
      t_pin();
      t_loss();
      wrap_up();
   end
endmodule
